// ===== stop_backup_power_control_defines.svh
// Constants for the stop, halt, backup flag and interrupt sequencer.
// Assumes an APB slave with 32-bit data and word-aligned registers.
//
// Overview of operation
// - Entering stop sets the backup flag so the crystal restarts reliably.
// - In stop every internal function and clock is frozen until release.
// - In stop all display common and segment outputs drive low.
// - Stop ends on held port C high, interrupt pin change, or enabled release.
// - Release from stop passes straight into halt, then normal halt release.
// - Port C high too short for the start flag returns the device to stop.
// - Interrupt that ended stop is serviced from halt; return goes back to stop.
// - Stop executed with a release pending enters halt instead.
// - Accepting an interrupt after stop release clears its halt release request.
// - Flag high gives large crystal driver; low gives small, except external supply.
// - Set-flag with operand 2h sets backup flag; clear-flag 2h clears it.
// - External supply option holds backup flag at 0 in and after reset.
// - Battery options force backup flag to 1 in and after reset.
// - Four sources with vectors 010H, 014H, 018H and 01CH.
// - Accepting an interrupt clears its request and every interrupt enable.
// - Pre-divider overflow is serviced first; other requests stay pending.
// - Accept pushes the program counter in one idle slot, then loads the vector.
// - With the pin wake enable set, any interrupt pin change releases stop.
`ifndef STOP_BACKUP_POWER_CONTROL_DEFINES_SVH
`define STOP_BACKUP_POWER_CONTROL_DEFINES_SVH

// ==========================================================
// Register offsets
`define REG_CTRL      12'h000
`define REG_FLAGS     12'h004
`define REG_STATUS    12'h008

// ==========================================================
// Control and flags register fields
`define CTRL_IEN_LSB  0
`define CTRL_SRF4_BIT 4
`define CTRL_STOP_WAKE_ON_IRQ_PIN_ENABLE_BIT 5
`define CTRL_HEN_LSB  6
`define FLAGS_SCF_BIT 4

// ==========================================================
// Source indices, vectors and flag operand
`define SRC_PORTC     2'h0
`define SRC_TIMER     2'h1
`define SRC_INTPIN    2'h2
`define SRC_PREDIV    2'h3
`define VEC_INTPIN    12'h010
`define VEC_PORTC     12'h014
`define VEC_TIMER     12'h018
`define VEC_PREDIV    12'h01c
`define BACKUP_OPER   4'h2

`endif

// ===== stop_backup_power_control_pkg.sv
// Types for the stop, halt, backup flag and interrupt sequencer.
// Assumes nothing of its surroundings.
`default_nettype none
package stop_backup_power_control_pkg;
    typedef enum logic [4:0] {
        ST_RUN  = 5'h01,
        ST_HALT = 5'h02,
        ST_STOP = 5'h04,
        ST_WAKE = 5'h08,
        ST_PUSH = 5'h10
    } mode_t;
endpackage : stop_backup_power_control_pkg
`default_nettype wire

// ===== stop_backup_power_control.sv
// Stop, halt, backup flag and four-source interrupt sequencer.
// Assumes single-cycle instruction pulses from the core on MCLK and
// asynchronous port C and interrupt pins.
`include "stop_backup_power_control_defines.svh"
`default_nettype none
module stop_backup_power_control #(
    parameter int PC_W      = 4,
    parameter int DEB_CYC   = 8,
    parameter bit INT_RISE  = 1'b1
) (
    // Clock and reset
    input  wire logic              MCLK,
    input  wire logic              RST,
    // APB slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [11:0]       PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // Core instruction strobes
    input  wire logic              STOP_EXEC,
    input  wire logic              HALT_EXEC,
    input  wire logic              RTS_EXEC,
    input  wire logic              SET_FLAG_INSTR,
    input  wire logic              CLEAR_FLAG_INSTR,
    input  wire logic [3:0]        FLAG_OPERAND,
    // Supply option strap and internal events
    input  wire logic              SUPPLY_EXT,
    input  wire logic              TIMER_ONE_UNDERFLOW,
    input  wire logic              PREDIV_OVERFLOW,
    // Wake pins
    input  wire logic [PC_W-1:0]   IO_PORT_C,
    input  wire logic              IRQ_PIN,
    // Core control
    output logic                   CLK_RUN,
    output logic                   HALTED,
    output logic                   LCD_FORCE_LOW,
    output logic                   XTAL_LARGE_DRV,
    output logic                   BACKUP_FLAG,
    output logic                   PUSH_PC,
    output logic                   VEC_LOAD,
    output logic      [11:0]       VECTOR
);

    // ==========================================================
    // Functions
    function automatic logic [1:0] pick_src(input logic [3:0] p);
        if (p[`SRC_PREDIV]) begin
            return `SRC_PREDIV;
        end else if (p[`SRC_TIMER]) begin
            return `SRC_TIMER;
        end else if (p[`SRC_PORTC]) begin
            return `SRC_PORTC;
        end
        return `SRC_INTPIN;
    endfunction : pick_src

    function automatic logic [11:0] vec_of(input logic [1:0] s);
        unique case (s)
            `SRC_PORTC:  return `VEC_PORTC;
            `SRC_TIMER:  return `VEC_TIMER;
            `SRC_INTPIN: return `VEC_INTPIN;
            `SRC_PREDIV: return `VEC_PREDIV;
        endcase
    endfunction : vec_of

    // ==========================================================
    // Pin synchronisers
    logic [PC_W-1:0] pc_s1_q, pc_s2_q, pc_s3_q, pc_f_q;
    logic            ip_s1_q, ip_s2_q, ip_s3_q, ip_f_q, ip_prev_q;

    always_ff @(posedge MCLK) begin
        pc_s1_q <= IO_PORT_C;
        pc_s2_q <= pc_s1_q;
        pc_s3_q <= pc_s2_q;
        ip_s1_q <= IRQ_PIN;
        ip_s2_q <= ip_s1_q;
        ip_s3_q <= ip_s2_q;
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            pc_f_q    <= '0;
            ip_f_q    <= 1'b0;
            ip_prev_q <= 1'b0;
        end else begin
            for (int i = 0; i < PC_W; i++) begin
                if (pc_s2_q[i] == pc_s3_q[i]) begin
                    pc_f_q[i] <= pc_s3_q[i];
                end
            end
            if (ip_s2_q == ip_s3_q) begin
                ip_f_q <= ip_s3_q;
            end
            ip_prev_q <= ip_f_q;
        end
    end

    logic pc_high, ip_chg, ip_edge;
    assign pc_high = |pc_f_q;
    assign ip_chg  = ip_f_q ^ ip_prev_q;
    assign ip_edge = ip_chg & (ip_f_q == INT_RISE);

    // ==========================================================
    // Control registers and state
    stop_backup_power_control_pkg::mode_t state_q, state_d, ret_q;
    logic [3:0] ien_q, hrf_q;
    logic [2:0] hen_q;
    logic       srf4_q, stop_wake_on_irq_pin_enable_q, scf_q, bf_q, from_stop_q, svc_q;
    logic [$clog2(DEB_CYC+1)-1:0] deb_q;

    logic wr, rd, acc_ok, accept, scf_set, halt_rel, stop_rel_req;
    logic [3:0] pend, hrf_set;
    logic [1:0] src;

    assign wr  = PSEL & PENABLE & PWRITE;
    assign rd  = PSEL & PENABLE & ~PWRITE;
    assign pend = hrf_q & ien_q;
    assign src  = pick_src(pend);
    assign acc_ok = state_q == stop_backup_power_control_pkg::ST_RUN
                  || state_q == stop_backup_power_control_pkg::ST_HALT;
    assign accept = acc_ok & (|pend);
    assign halt_rel = scf_q | (|(hrf_q[3:1] & hen_q));
    assign stop_rel_req = (stop_wake_on_irq_pin_enable_q & ip_chg) | (srf4_q & pc_high) | (|pend);
    assign scf_set = state_q != stop_backup_power_control_pkg::ST_STOP
                   && pc_high && deb_q == ($bits(deb_q))'(DEB_CYC);

    // Request sources; internal events are frozen in stop
    always_comb begin
        hrf_set = '0;
        hrf_set[`SRC_PORTC]  = scf_set & ~scf_q;
        hrf_set[`SRC_INTPIN] = ip_edge;
        if (state_q != stop_backup_power_control_pkg::ST_STOP) begin
            hrf_set[`SRC_TIMER]  = TIMER_ONE_UNDERFLOW;
            hrf_set[`SRC_PREDIV] = PREDIV_OVERFLOW;
        end
    end

    // ==========================================================
    // Port C high-level qualification
    always_ff @(posedge MCLK) begin
        if (RST || !pc_high) begin
            deb_q <= '0;
        end else if (state_q != stop_backup_power_control_pkg::ST_STOP
                     && deb_q != ($bits(deb_q))'(DEB_CYC)) begin
            deb_q <= deb_q + 1'b1;
        end
    end

    // ==========================================================
    // Mode sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            stop_backup_power_control_pkg::ST_RUN: begin
                if (accept) begin
                    state_d = stop_backup_power_control_pkg::ST_PUSH;
                end else if (svc_q && RTS_EXEC) begin
                    state_d = ret_q;
                end else if (STOP_EXEC) begin
                    state_d = stop_rel_req ? stop_backup_power_control_pkg::ST_HALT
                                           : stop_backup_power_control_pkg::ST_STOP;
                end else if (HALT_EXEC && !halt_rel) begin
                    state_d = stop_backup_power_control_pkg::ST_HALT;
                end
            end
            stop_backup_power_control_pkg::ST_HALT: begin
                if (accept) begin
                    state_d = stop_backup_power_control_pkg::ST_PUSH;
                end else if (halt_rel) begin
                    state_d = stop_backup_power_control_pkg::ST_RUN;
                end
            end
            stop_backup_power_control_pkg::ST_STOP: begin
                if ((stop_wake_on_irq_pin_enable_q && ip_chg) || (|pend)) begin
                    state_d = stop_backup_power_control_pkg::ST_HALT;
                end else if (srf4_q && pc_high) begin
                    state_d = stop_backup_power_control_pkg::ST_WAKE;
                end
            end
            stop_backup_power_control_pkg::ST_WAKE: begin
                if (scf_q || accept) begin
                    state_d = stop_backup_power_control_pkg::ST_HALT;
                end else if (!pc_high) begin
                    state_d = stop_backup_power_control_pkg::ST_STOP;
                end
            end
            stop_backup_power_control_pkg::ST_PUSH: begin
                state_d = stop_backup_power_control_pkg::ST_RUN;
            end
            default: state_d = stop_backup_power_control_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_q     <= stop_backup_power_control_pkg::ST_RUN;
            ret_q       <= stop_backup_power_control_pkg::ST_RUN;
            from_stop_q <= 1'b0;
            svc_q       <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == stop_backup_power_control_pkg::ST_STOP) begin
                from_stop_q <= 1'b1;
            end else if (state_d == stop_backup_power_control_pkg::ST_RUN
                         && state_q == stop_backup_power_control_pkg::ST_HALT) begin
                from_stop_q <= 1'b0;
            end
            if (accept) begin
                svc_q <= 1'b1;
                if (state_q == stop_backup_power_control_pkg::ST_RUN) begin
                    ret_q <= stop_backup_power_control_pkg::ST_RUN;
                end else if (from_stop_q) begin
                    ret_q <= stop_backup_power_control_pkg::ST_STOP;
                end else begin
                    ret_q <= stop_backup_power_control_pkg::ST_HALT;
                end
            end else if (svc_q && RTS_EXEC
                         && state_q == stop_backup_power_control_pkg::ST_RUN) begin
                svc_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Interrupt acceptance and vector
    always_ff @(posedge MCLK) begin
        if (RST) begin
            PUSH_PC  <= 1'b0;
            VEC_LOAD <= 1'b0;
            VECTOR   <= '0;
        end else begin
            PUSH_PC  <= accept;
            VEC_LOAD <= PUSH_PC;
            if (accept) begin
                VECTOR <= vec_of(src);
            end
        end
    end

    // ==========================================================
    // Request, start and enable flags; a set wins over a clear, but an accept clears the enables over a write
    always_ff @(posedge MCLK) begin
        if (RST) begin
            hrf_q  <= '0;
            scf_q  <= 1'b0;
            ien_q  <= '0;
            hen_q  <= '0;
            srf4_q <= 1'b0;
            stop_wake_on_irq_pin_enable_q <= 1'b0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (hrf_set[i]) begin
                    hrf_q[i] <= 1'b1;
                end else if ((accept && src == 2'(i))
                             || (wr && PADDR == `REG_FLAGS && PWDATA[i])) begin
                    hrf_q[i] <= 1'b0;
                end
            end
            if (scf_set) begin
                scf_q <= 1'b1;
            end else if (wr && PADDR == `REG_FLAGS && PWDATA[`FLAGS_SCF_BIT]) begin
                scf_q <= 1'b0;
            end
            if (accept) begin
                ien_q <= '0;
            end else if (wr && PADDR == `REG_CTRL) begin
                ien_q <= PWDATA[`CTRL_IEN_LSB +: 4];
            end
            if (wr && PADDR == `REG_CTRL) begin
                hen_q  <= PWDATA[`CTRL_HEN_LSB +: 3];
                srf4_q <= PWDATA[`CTRL_SRF4_BIT];
                stop_wake_on_irq_pin_enable_q <= PWDATA[`CTRL_STOP_WAKE_ON_IRQ_PIN_ENABLE_BIT];
            end
        end
    end

    // ==========================================================
    // Backup flag
    always_ff @(posedge MCLK) begin
        if (RST) begin
            bf_q <= ~SUPPLY_EXT;
        end else if (state_d == stop_backup_power_control_pkg::ST_STOP
                     && state_q != stop_backup_power_control_pkg::ST_STOP) begin
            bf_q <= 1'b1;
        end else if (SET_FLAG_INSTR && FLAG_OPERAND == `BACKUP_OPER) begin
            bf_q <= 1'b1;
        end else if (CLEAR_FLAG_INSTR && FLAG_OPERAND == `BACKUP_OPER) begin
            bf_q <= 1'b0;
        end
    end

    // ==========================================================
    // Outputs
    assign BACKUP_FLAG    = bf_q;
    assign XTAL_LARGE_DRV = bf_q | SUPPLY_EXT;
    assign CLK_RUN        = state_q != stop_backup_power_control_pkg::ST_STOP;
    assign LCD_FORCE_LOW  = state_q == stop_backup_power_control_pkg::ST_STOP;
    assign HALTED         = state_q != stop_backup_power_control_pkg::ST_RUN
                          && state_q != stop_backup_power_control_pkg::ST_PUSH;

    // ==========================================================
    // APB read path
    logic mapped;
    assign mapped  = PADDR == `REG_CTRL || PADDR == `REG_FLAGS || PADDR == `REG_STATUS;
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            PRDATA <= '0;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            unique case (PADDR)
                `REG_CTRL:   PRDATA <= {26'h0, stop_wake_on_irq_pin_enable_q, srf4_q, ien_q} |
                                       {23'h0, hen_q, 6'h0};
                `REG_FLAGS:  PRDATA <= {27'h0, scf_q, hrf_q};
                `REG_STATUS: PRDATA <= {18'h0, VECTOR[7:0], state_q, bf_q};
                default:     PRDATA <= '0;
            endcase
        end
    end

    // ==========================================================
    // Checks
    AST_BF_STOP: assert property (@(posedge MCLK) disable iff (RST)
        (state_q != stop_backup_power_control_pkg::ST_STOP
         ##1 state_q == stop_backup_power_control_pkg::ST_STOP) |-> bf_q)
        else $error("backup flag not set in stop");
    AST_FREEZE: assert property (@(posedge MCLK) disable iff (RST)
        LCD_FORCE_LOW |-> !CLK_RUN && $stable(hrf_q[`SRC_TIMER]) || hrf_q[`SRC_TIMER])
        else $error("activity during stop");
    AST_LCD_LOW: assert property (@(posedge MCLK) disable iff (RST)
        state_q == stop_backup_power_control_pkg::ST_RUN && STOP_EXEC && !stop_rel_req
        && !accept && !(svc_q && RTS_EXEC) |=> LCD_FORCE_LOW)
        else $error("display not low in stop");
    AST_PIN_WAKE: assert property (@(posedge MCLK) disable iff (RST)
        state_q == stop_backup_power_control_pkg::ST_STOP && stop_wake_on_irq_pin_enable_q && ip_chg
        |=> state_q == stop_backup_power_control_pkg::ST_HALT)
        else $error("pin change did not release stop");
    AST_SHORT_HIGH: assert property (@(posedge MCLK) disable iff (RST)
        state_q == stop_backup_power_control_pkg::ST_WAKE && !scf_q && !pc_high && !accept
        |=> state_q == stop_backup_power_control_pkg::ST_STOP)
        else $error("no return to stop");
    AST_STOP_PEND: assert property (@(posedge MCLK) disable iff (RST)
        state_q == stop_backup_power_control_pkg::ST_RUN && STOP_EXEC && stop_rel_req
        && !accept && !(svc_q && RTS_EXEC)
        |=> state_q == stop_backup_power_control_pkg::ST_HALT)
        else $error("stop entered with release pending");
    AST_ACCEPT_CLR: assert property (@(posedge MCLK) disable iff (RST)
        accept |=> ien_q == 4'h0 ##1 VEC_LOAD)
        else $error("enables not cleared on accept");
    AST_PRIO: assert property (@(posedge MCLK) disable iff (RST)
        accept && pend[`SRC_PREDIV] |=> VECTOR == `VEC_PREDIV)
        else $error("pre-divider not first");
    AST_DRIVER: assert property (@(posedge MCLK) disable iff (RST)
        XTAL_LARGE_DRV == (BACKUP_FLAG || SUPPLY_EXT))
        else $error("crystal driver wrong");
    AST_HALT_BF: assert property (@(posedge MCLK) disable iff (RST)
        state_q == stop_backup_power_control_pkg::ST_HALT && !SET_FLAG_INSTR
        && !CLEAR_FLAG_INSTR |=> $stable(bf_q))
        else $error("halt changed backup flag");

endmodule : stop_backup_power_control
`default_nettype wire

// ===== stop_wake_pins.sv
// Partner model of the external wake inputs: port C pins and interrupt pin.
// Assumes the bench calls its tasks from the MCLK domain.
`default_nettype none
module stop_wake_pins #(
    parameter int PC_W = 4
) (
    // Clock
    input  wire logic            MCLK,
    // Wake pins
    output logic      [PC_W-1:0] IO_PORT_C,
    output logic                 IRQ_PIN
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        IO_PORT_C = '0;
        IRQ_PIN   = 1'b0;
    end
    // ====================
    // Pin stimulus
    task automatic idle();
        @(posedge MCLK);
        IO_PORT_C <= '0;
        IRQ_PIN   <= 1'b0;
    endtask : idle
    task automatic irq_set(input logic lvl);
        @(posedge MCLK);
        IRQ_PIN <= lvl;
    endtask : irq_set
    task automatic port_c(input logic [PC_W-1:0] pat, input int len);
        @(posedge MCLK);
        IO_PORT_C <= pat;
        repeat (len) @(posedge MCLK);
        IO_PORT_C <= '0;
    endtask : port_c
endmodule : stop_wake_pins
`default_nettype wire

// ===== stop_backup_power_control_bench.sv
// Self-checking bench for the stop, halt, backup flag and interrupt block.
// Assumes the design files and the wake pin model are compiled first.
`include "stop_backup_power_control_defines.svh"
`default_nettype none
module stop_backup_power_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PC_W = 4;
    localparam int DEB  = 8;
    logic            mclk, rst, psel, penable, pwrite, supply_ext, pready, pslverr, err;
    logic [11:0]     paddr, vector;
    logic [31:0]     pwdata, prdata, rd;
    logic [6:0]      ins;
    logic [3:0]      oper, rop;
    logic [PC_W-1:0] port_c, pat;
    logic            irq_pin, clk_run, halted, lcd_low, xtal_large, backup, push_pc, vec_load;
    int              miscompares, comparisons, cycles, seed, i;
    stop_backup_power_control #(.PC_W(PC_W), .DEB_CYC(DEB)) DUT (
        .MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .STOP_EXEC(ins[0]), .HALT_EXEC(ins[1]), .RTS_EXEC(ins[2]),
        .SET_FLAG_INSTR(ins[3]), .CLEAR_FLAG_INSTR(ins[4]), .FLAG_OPERAND(oper),
        .SUPPLY_EXT(supply_ext), .TIMER_ONE_UNDERFLOW(ins[5]), .PREDIV_OVERFLOW(ins[6]),
        .IO_PORT_C(port_c), .IRQ_PIN(irq_pin), .CLK_RUN(clk_run), .HALTED(halted),
        .LCD_FORCE_LOW(lcd_low), .XTAL_LARGE_DRV(xtal_large), .BACKUP_FLAG(backup),
        .PUSH_PC(push_pc), .VEC_LOAD(vec_load), .VECTOR(vector));
    stop_wake_pins #(.PC_W(PC_W)) pins (.MCLK(mclk), .IO_PORT_C(port_c), .IRQ_PIN(irq_pin));
    // ====================
    // Clock and timeout
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            final_report();
        end
    end
    // ====================
    // Checks and bus tasks
    task automatic final_report();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask : chk_bit
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb
    task automatic pulse(input logic [6:0] v, input logic [3:0] op);
        @(posedge mclk);
        ins  <= v;
        oper <= op;
        @(posedge mclk);
        ins <= '0;
        #1;
    endtask : pulse
    task automatic wait_pair(input logic [1:0] e);
        int n;
        n = 0;
        #1;
        while ({clk_run, lcd_low} !== e && n < 60) begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask : wait_pair
    task automatic take_irq(input logic [11:0] v);
        int n;
        n = 0;
        while (push_pc !== 1'b1 && n < 60) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk_bit(push_pc, 1'b1);
        @(posedge mclk);
        #1;
        chk_bit(vec_load, 1'b1);
        chk_word({20'h0, vector}, {20'h0, v});
    endtask : take_irq
    task automatic do_reset(input logic sup);
        @(posedge mclk);
        rst <= 1'b1;
        supply_ext <= sup;
        pins.idle();
        repeat (3) @(posedge mclk);
        #1;
        chk_bit(backup, ~sup);
        @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        chk_bit(backup, ~sup);
    endtask : do_reset
    // ====================
    // Main sequence
    initial begin
        seed = 32'he32e7aea;
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, ins, oper, supply_ext} = '0;
        {miscompares, comparisons, cycles} = '0;
        for (i = 1; i >= 0; i--) begin
            do_reset(i[0]);
            chk_bit(xtal_large, 1'b1);
            apb(1'b0, `REG_STATUS, 32'h0);
            chk_bit(rd[0], ~supply_ext);
            pulse(7'h10, 4'h2);
            chk_bit(backup, 1'b0);
            chk_bit(xtal_large, supply_ext);
            rop = 4'($random(seed));
            rop = (rop == 4'h2) ? 4'ha : rop;
            pulse(7'h08, rop);
            chk_bit(backup, 1'b0);
            pulse(7'h08, 4'h2);
            chk_bit(backup, 1'b1);
            pulse(7'h02, 4'h0);
            chk_bit(halted, 1'b1);
            chk_bit(backup, 1'b1);
            apb(1'b1, `REG_CTRL, 32'h40);
            pulse(7'h20, 4'h0);
            @(posedge mclk);
            #1;
            chk_bit(halted, 1'b0);
            $display("test flags done");
        end
        apb(1'b0, 12'h00c, 32'h0);
        chk_bit(err, 1'b1);
        chk_word(rd, 32'h0);
        do_reset(1'b0);
        pulse(7'h10, 4'h2);
        apb(1'b1, `REG_CTRL, 32'h20);
        pulse(7'h01, 4'h0);
        chk_bit(clk_run, 1'b0);
        chk_bit(lcd_low, 1'b1);
        chk_bit(backup, 1'b1);
        pins.irq_set(1'b1);
        wait_pair(2'b10);
        chk_bit(halted, 1'b1);
        chk_bit(backup, 1'b1);
        pulse(7'h10, 4'h2);
        chk_bit(backup, 1'b0);
        $display("test stop pin done");
        do_reset(1'b0);
        apb(1'b1, `REG_CTRL, 32'h10);
        pulse(7'h01, 4'h0);
        pat = PC_W'($random(seed)) | PC_W'(1);
        pins.port_c(pat, 5);
        wait_pair(2'b10);
        chk_bit(halted, 1'b1);
        wait_pair(2'b01);
        chk_bit(clk_run, 1'b0);
        chk_bit(lcd_low, 1'b1);
        pins.port_c(pat, DEB + 12 + ($random(seed) & 3));
        wait_pair(2'b10);
        chk_bit(clk_run, 1'b1);
        apb(1'b0, `REG_FLAGS, 32'h0);
        chk_bit(rd[4], 1'b1);
        $display("test stop port done");
        do_reset(1'b0);
        apb(1'b1, `REG_CTRL, 32'h10);
        fork
            pins.port_c(pat, 12);
            begin
                repeat (6) @(posedge mclk);
                pulse(7'h01, 4'h0);
                chk_bit(lcd_low, 1'b0);
                chk_bit(clk_run, 1'b1);
                chk_bit(halted, 1'b1);
            end
        join
        $display("test pending stop done");
        do_reset(1'b0);
        apb(1'b1, `REG_CTRL, 32'hf);
        pulse(7'h60, 4'h0);
        take_irq(12'h01c);
        apb(1'b0, `REG_CTRL, 32'h0);
        chk_word(rd & 32'hf, 32'h0);
        apb(1'b0, `REG_FLAGS, 32'h0);
        chk_word(rd & 32'hf, 32'h2);
        apb(1'b1, `REG_CTRL, 32'hf);
        take_irq(12'h018);
        apb(1'b1, `REG_CTRL, 32'h24);
        pulse(7'h01, 4'h0);
        chk_bit(lcd_low, 1'b1);
        pins.irq_set(1'b1);
        take_irq(12'h010);
        apb(1'b0, `REG_FLAGS, 32'h0);
        chk_bit(rd[2], 1'b0);
        pulse(7'h04, 4'h0);
        wait_pair(2'b01);
        chk_bit(lcd_low, 1'b1);
        $display("test interrupts done");
        final_report();
    end
endmodule : stop_backup_power_control_bench
`default_nettype wire
